// *** core/scc_pkg.sv ***
// Purpose: constants and types for the sar conversion mode control block
// Assumes: 125 MHz clock, 8 ns period
// Notes:   cycle counts derive from printed rates and times
// ==========================================================================
// package
package scc_pkg;

    localparam int          SCC_CLK_MHZ      = 125;
    localparam int          SCC_BITS         = 16;
    localparam logic [15:0] SCC_CODE_RST     = 16'h0000;
    localparam logic [15:0] SCC_MSB_WEIGHT   = 16'h8000;
    localparam logic [4:0]  SCC_BIT_CNT_RST  = 5'h00;

    // throughput limits in kilosamples per second; least period rounds up
    localparam int SCC_WARP_KSPS    = 3000;
    localparam int SCC_NORMAL_KSPS  = 2000;
    localparam int SCC_IMPULSE_KSPS = 1250;
    localparam int SCC_WARP_CYC    = (SCC_CLK_MHZ * 1000 + SCC_WARP_KSPS - 1) / SCC_WARP_KSPS;
    localparam int SCC_NORMAL_CYC  = (SCC_CLK_MHZ * 1000 + SCC_NORMAL_KSPS - 1)
                                     / SCC_NORMAL_KSPS;
    localparam int SCC_IMPULSE_CYC = (SCC_CLK_MHZ * 1000 + SCC_IMPULSE_KSPS - 1)
                                     / SCC_IMPULSE_KSPS;

    // warp idle limit: 1 ms
    localparam int SCC_WARP_IDLE_MS  = 1;
    localparam int SCC_WARP_IDLE_CYC = SCC_WARP_IDLE_MS * SCC_CLK_MHZ * 1000;

    // calibration pulse length after reset release
    localparam int SCC_CAL_CYC = 16;

    localparam logic [7:0]  SCC_PERIOD_RST = 8'h00;
    localparam logic [7:0]  SCC_CAL_RST    = 8'h00;

    typedef enum logic [1:0]
    {
        SCC_MODE_NORMAL   = 2'h0,
        SCC_MODE_IMPULSE  = 2'h1,
        SCC_MODE_WARP     = 2'h2,
        SCC_MODE_WB_WARP  = 2'h3
    } scc_mode_type;

    typedef enum logic [6:0]
    {
        SCC_ST_CAL     = 7'h01,
        SCC_ST_ACQ     = 7'h02,
        SCC_ST_GND_OPEN = 7'h04,
        SCC_ST_REF_GND = 7'h08,
        SCC_ST_SEARCH  = 7'h10,
        SCC_ST_DONE    = 7'h20,
        SCC_ST_SLEEP   = 7'h40
    } scc_state_type;

    // switch drive to the analog arrays
    typedef struct packed
    {
        logic        pos_input_ground_switch;
        logic        neg_input_ground_switch;
        logic        arrays_to_input;
        logic        arrays_to_reference_ground;
        logic [15:0] dac_ref_select;
    } scc_switch_type;

    typedef struct packed
    {
        logic        code_valid;
        logic [15:0] code;
    } scc_result_type;

endpackage : scc_pkg

// *** core/scc_conversion_ctrl.sv ***
// Purpose: control sequence of a 16 bit successive approximation converter
// Assumes: all pins synchronous to clk; comparator output valid one cycle
//          after the dac drive changes
// Notes:   throughput caps enforced by holding off starts until the mode's
//          least conversion period has elapsed
// ==========================================================================
`timescale 1ns/10ps

module scc_conversion_ctrl
(
    input  wire logic                  clk,                // 125 MHz clock
    input  wire logic                  resetn,             // sync reset, active low
    input  wire logic                  conversion_start_n, // start strobe, falling edge
    input  wire logic                  fast_mode,          // warp mode pin
    input  wire logic                  low_power_mode,     // impulse mode pin
    input  wire logic                  power_down_in,      // inhibit further conversions
    input  wire logic                  comparator_high,    // comparator says trial too big
    output scc_pkg::scc_switch_type    switch_drive,       // array switch controls
    output scc_pkg::scc_result_type    result,             // output code and valid
    output logic                       busy,               // conversion or calibration
    output logic                       hold,               // sample-and-hold in hold
    output logic                       circuits_powered,   // analog circuits enabled
    output logic                       warp_stale          // first result after long gap
);
    import scc_pkg::*;

    // ======================================================================
    // mode decode
    function automatic scc_mode_type decode_mode(input logic f, input logic lp);
        decode_mode = scc_mode_type'({f, lp});
    endfunction : decode_mode

    function automatic int min_period(input scc_mode_type m);
        unique case (m)
            SCC_MODE_WB_WARP, SCC_MODE_WARP: min_period = SCC_WARP_CYC;
            SCC_MODE_NORMAL:                 min_period = SCC_NORMAL_CYC;
            SCC_MODE_IMPULSE:                min_period = SCC_IMPULSE_CYC;
        endcase
    endfunction : min_period

    // ======================================================================
    // state
    scc_state_type  state_ff,    nxt_state;
    logic           start_d_ff,  nxt_start_d;
    logic [15:0]    trial_ff,    nxt_trial;
    logic [15:0]    code_ff,     nxt_code;
    logic [4:0]     bit_ff,      nxt_bit;
    logic [7:0]     period_ff,   nxt_period;
    logic [7:0]     cal_ff,      nxt_cal;
    logic [27:0]    idle_ff,     nxt_idle;
    logic           stale_ff,    nxt_stale;
    logic           valid_ff,    nxt_valid;
    logic           pwr_ff,      nxt_pwr;
    scc_mode_type   mode;
    logic           start_fall;
    logic           period_met;
    logic           warp_mode;

    assign mode       = decode_mode(fast_mode, low_power_mode);
    assign warp_mode  = (mode == SCC_MODE_WARP) || (mode == SCC_MODE_WB_WARP);
    assign start_fall = start_d_ff && !conversion_start_n;
    // the counter restarts at zero on the taking edge, so it reads one less than
    // the cycles elapsed; a start exactly one least period later is accepted
    assign period_met = ((32'(period_ff) + 32'd1) >= min_period(mode));

    // ======================================================================
    // next state
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_start_d = conversion_start_n;
        nxt_trial   = trial_ff;
        nxt_code    = code_ff;
        nxt_bit     = bit_ff;
        nxt_period  = (period_ff == 8'hff) ? period_ff : period_ff + 8'h01;
        nxt_cal     = cal_ff;
        nxt_idle    = (idle_ff == 28'hfffffff) ? idle_ff : idle_ff + 28'h0000001;
        nxt_stale   = stale_ff;
        nxt_valid   = valid_ff;
        nxt_pwr     = pwr_ff;

        unique case (state_ff)
            SCC_ST_CAL:
            begin
                // calibration pulse after reset release
                nxt_cal = cal_ff + 8'h01;
                if (32'(cal_ff) >= SCC_CAL_CYC - 1)
                begin
                    nxt_state = SCC_ST_ACQ;
                end
            end
            SCC_ST_ACQ, SCC_ST_SLEEP:
            begin
                // start honoured only once the previous period has elapsed,
                // which caps throughput per mode; power down blocks new starts
                if (start_fall && period_met && !power_down_in)
                begin
                    nxt_state  = SCC_ST_GND_OPEN;
                    nxt_period = SCC_PERIOD_RST;
                    nxt_valid  = 1'b0;
                    nxt_pwr    = 1'b1;
                    // gap over 1 ms in warp: flag result for the host
                    nxt_stale  = warp_mode && (32'(idle_ff) > SCC_WARP_IDLE_CYC);
                end
            end
            SCC_ST_GND_OPEN:
            begin
                nxt_state = SCC_ST_REF_GND;
            end
            SCC_ST_REF_GND:
            begin
                nxt_state = SCC_ST_SEARCH;
                nxt_trial = SCC_MSB_WEIGHT;
                nxt_code  = SCC_MSB_WEIGHT;
                nxt_bit   = SCC_BIT_CNT_RST;
            end
            SCC_ST_SEARCH:
            begin
                // keep or drop the trial bit, then try the next lower one
                if (comparator_high)
                begin
                    nxt_code = code_ff & ~trial_ff;
                end
                nxt_trial = trial_ff >> 1;
                nxt_code  = (comparator_high ? (code_ff & ~trial_ff) : code_ff)
                            | (trial_ff >> 1);
                nxt_bit   = bit_ff + 5'h01;
                if (32'(bit_ff) == SCC_BITS - 1)
                begin
                    nxt_state = SCC_ST_DONE;
                    nxt_code  = comparator_high ? (code_ff & ~trial_ff) : code_ff;
                end
            end
            SCC_ST_DONE:
            begin
                nxt_valid = 1'b1;
                nxt_idle  = 28'h0000000;
                if (mode == SCC_MODE_IMPULSE || power_down_in)
                begin
                    nxt_state = SCC_ST_SLEEP;
                    nxt_pwr   = 1'b0;
                end
                else
                begin
                    nxt_state = SCC_ST_ACQ;
                end
            end
            default:
            begin
                nxt_state = SCC_ST_ACQ;
            end
        endcase
    end

    // ======================================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            // reset aborts any conversion; release enters calibration
            state_ff   <= SCC_ST_CAL;
            start_d_ff <= 1'b1;
            trial_ff   <= SCC_CODE_RST;
            code_ff    <= SCC_CODE_RST;
            bit_ff     <= SCC_BIT_CNT_RST;
            period_ff  <= 8'hff;
            cal_ff     <= SCC_CAL_RST;
            idle_ff    <= 28'h0000000;
            stale_ff   <= 1'b0;
            valid_ff   <= 1'b0;
            pwr_ff     <= 1'b1;
        end
        else
        begin
            state_ff   <= nxt_state;
            start_d_ff <= nxt_start_d;
            trial_ff   <= nxt_trial;
            code_ff    <= nxt_code;
            bit_ff     <= nxt_bit;
            period_ff  <= nxt_period;
            cal_ff     <= nxt_cal;
            idle_ff    <= nxt_idle;
            stale_ff   <= nxt_stale;
            valid_ff   <= nxt_valid;
            pwr_ff     <= nxt_pwr;
        end
    end

    // ======================================================================
    // outputs straight from flip-flops
    scc_switch_type sw_ff, nxt_sw;
    logic           busy_ff, nxt_busy;
    logic           hold_ff, nxt_hold;

    always_comb
    begin
        nxt_sw.pos_input_ground_switch    = (nxt_state == SCC_ST_ACQ)
                                            || (nxt_state == SCC_ST_SLEEP);
        nxt_sw.neg_input_ground_switch    = nxt_sw.pos_input_ground_switch;
        nxt_sw.arrays_to_input            = nxt_sw.pos_input_ground_switch
                                            || (nxt_state == SCC_ST_GND_OPEN);
        nxt_sw.arrays_to_reference_ground = (nxt_state == SCC_ST_REF_GND)
                                            || (nxt_state == SCC_ST_SEARCH);
        nxt_sw.dac_ref_select             = (nxt_state == SCC_ST_SEARCH) ? nxt_code
                                            : SCC_CODE_RST;
        nxt_busy = !((nxt_state == SCC_ST_ACQ) || (nxt_state == SCC_ST_SLEEP));
        // calibration holds no sample, so hold stays low there
        nxt_hold = (nxt_state == SCC_ST_GND_OPEN) || (nxt_state == SCC_ST_REF_GND)
                   || (nxt_state == SCC_ST_SEARCH) || (nxt_state == SCC_ST_DONE);
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sw_ff   <= '0;
            busy_ff <= 1'b1;
            hold_ff <= 1'b0;
        end
        else
        begin
            sw_ff   <= nxt_sw;
            busy_ff <= nxt_busy;
            hold_ff <= nxt_hold;
        end
    end

    assign switch_drive      = sw_ff;
    assign busy              = busy_ff;
    assign hold              = hold_ff;
    assign result            = '{code_valid: valid_ff, code: code_ff};
    assign circuits_powered  = pwr_ff;
    assign warp_stale        = stale_ff;

endmodule : scc_conversion_ctrl

// *** tb/scc_ctrl_asserts.sv ***
// Purpose: port assertions for the conversion control block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every instance of scc_conversion_ctrl
`timescale 1ns/10ps
// ==========================================================
// checker
module scc_ctrl_asserts
(
    input wire logic               clk,                // clock
    input wire logic               resetn,             // reset
    input wire logic               conversion_start_n, // start
    input wire logic               fast_mode,          // mode pin
    input wire logic               low_power_mode,     // mode pin
    input wire logic               power_down_in,      // inhibit
    input wire logic               comparator_high,    // comparator
    input scc_pkg::scc_switch_type switch_drive,       // switches
    input scc_pkg::scc_result_type result,             // code
    input wire logic               busy,               // busy
    input wire logic               hold,               // held
    input wire logic               circuits_powered,   // powered
    input wire logic               warp_stale          // stale
);
    import scc_pkg::*;
    wire logic gnd_pos   = switch_drive.pos_input_ground_switch;
    wire logic gnd_neg   = switch_drive.neg_input_ground_switch;
    wire logic to_input  = switch_drive.arrays_to_input;
    wire logic to_reference_ground = switch_drive.arrays_to_reference_ground;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_start_edge: assert property ($rose(hold) |-> $past(conversion_start_n, 2) &&
        !$past(conversion_start_n)) else $error("hold without start edge");
    a_acq_switches: assert property (!busy && circuits_powered && result.code_valid
        |-> to_input && gnd_pos && gnd_neg) else $error("acquire switches wrong");
    a_ground_first: assert property ($rose(hold) |-> !gnd_pos && !gnd_neg && to_input
        ##1 to_reference_ground && !to_input) else $error("switch order wrong");
    a_msb_first: assert property ($rose(to_reference_ground) |=>
        switch_drive.dac_ref_select == SCC_MSB_WEIGHT) else $error("first trial not msb");
    a_conv_length: assert property ($rose(hold) |-> !result.code_valid
        ##19 ($fell(busy) && result.code_valid)) else $error("conversion length wrong");
    a_impulse_sleep: assert property ($rose(result.code_valid) && !fast_mode
        && low_power_mode |-> !circuits_powered) else $error("impulse left powered");
    a_cal_pulse: assert property ($rose(resetn) |-> busy[*8] ##8 busy
        ##[1:3] !busy) else $error("calibration pulse wrong");
    a_pd_inhibit: assert property (power_down_in && $fell(conversion_start_n)
        |=> !$rose(hold)) else $error("start taken in power down");

    c_conv:  cover property ($rose(hold));
    c_sleep: cover property ($fell(circuits_powered));
    c_pd:    cover property (power_down_in && $fell(conversion_start_n));
endmodule : scc_ctrl_asserts

bind scc_conversion_ctrl scc_ctrl_asserts u_chk (.clk(clk), .resetn(resetn),
    .conversion_start_n(conversion_start_n), .fast_mode(fast_mode),
    .low_power_mode(low_power_mode), .power_down_in(power_down_in),
    .comparator_high(comparator_high), .switch_drive(switch_drive), .result(result),
    .busy(busy), .hold(hold), .circuits_powered(circuits_powered),
    .warp_stale(warp_stale));

// *** tb/scc_analog_model.sv ***
// Purpose: behavioural analog side: sampler and comparator
// Assumes: input level given as the ideal output code
// Notes:   comparator output toggles outside conversions
`timescale 1ns/10ps
// ==========================================================
// model
module scc_analog_model
(
    input  wire logic        clk,            // clock
    input  wire logic        hold,           // sample held
    input  wire logic [15:0] dac,            // trial code
    input  wire logic [15:0] level,          // live input
    output logic             comparator_high // trial too big
);
    logic [15:0] smp_ff;
    logic        held_ff;
    logic        tog_ff = 1'b0;
    always_ff @(posedge clk)
    begin
        held_ff <= hold;
        tog_ff  <= ~tog_ff;
        if (hold && !held_ff)
            smp_ff <= level;
    end
    // no defined answer outside a conversion, so never a steady level
    assign comparator_high = hold ? (dac > smp_ff) : tog_ff;
endmodule : scc_analog_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the conversion control block
// Assumes: mode pins stay put during a conversion
// Notes:   seeded random levels mixed with end-scale codes
`timescale 1ns/10ps
// ==========================================================
// bench
module tb_top;
    import scc_pkg::*;
    logic           clk, resetn, cs_n, fast, lp, pd, cmp, busy, hold, pwr, stale;
    logic [15:0]    level, r;
    scc_switch_type sw;
    scc_result_type res;
    int             n_errors, checks_done;

    scc_conversion_ctrl dut (.clk(clk), .resetn(resetn), .conversion_start_n(cs_n),
        .fast_mode(fast), .low_power_mode(lp), .power_down_in(pd), .comparator_high(cmp),
        .switch_drive(sw), .result(res), .busy(busy), .hold(hold), .circuits_powered(pwr),
        .warp_stale(stale));
    scc_analog_model model (.clk(clk), .hold(hold), .dac(sw.dac_ref_select),
        .level(level), .comparator_high(cmp));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    function automatic logic [15:0] sar(input logic [15:0] s);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 15; i >= 0; i--)
        begin
            c[i] = 1'b1;
            if (c > s)
                c[i] = 1'b0;
        end
        return c;
    endfunction : sar

    function automatic int period(input int m);
        return (m >= 2) ? SCC_WARP_CYC : (m == 0) ? SCC_NORMAL_CYC : SCC_IMPULSE_CYC;
    endfunction : period

    task automatic wait_idle();
        int i;
        for (i = 0; i < 40 && busy !== 1'b0; i++)
            @(negedge clk);
        if (i == 40)
        begin
            n_errors++;
            conclude();
        end
    endtask : wait_idle

    task automatic pulse();
        @(negedge clk) cs_n = 1'b0;
        @(negedge clk) cs_n = 1'b1;
    endtask : pulse

    // the refused pulse lands two cycles short of the least period
    task automatic gap(input int p);
        repeat (p - 24) @(negedge clk);
        pulse();
        chk(busy, 1'b0);
    endtask : gap

    task automatic conv(input logic [15:0] s, input int m);
        level = s;
        pulse();
        @(negedge clk);
        chk(busy, 1'b1);
        chk(hold, 1'b1);
        repeat (2) @(negedge clk);
        level = ~s;
        repeat (17) @(negedge clk);
        chk(busy, 1'b0);
        chk(res.code_valid, 1'b1);
        chk(res.code, sar(s));
        chk(pwr, m != 1);
        chk(hold, 1'b0);
        chk(sw.arrays_to_input, 1'b1);
        chk(stale, 1'b0);
    endtask : conv

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial
    begin
        {resetn, cs_n, fast, lp, pd, level, n_errors, checks_done} = '0;
        cs_n = 1'b1;
        void'($urandom(83253));
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        wait_idle();
        conv(16'h8000, 0);
        for (int m = 0; m < 4; m++)
        begin
            {fast, lp} = m[1:0];
            for (int k = 0; k < 3; k++)
            begin
                r = 16'($urandom);
                gap(period(m));
                conv(k == 0 ? 16'h0000 : k == 1 ? 16'hffff : r, m);
            end
            $display("mode %0d done", m);
        end
        {fast, lp} = 2'b00;
        pd = 1'b1;
        gap(63);
        pulse();
        @(negedge clk);
        chk(busy, 1'b0);
        pd = 1'b0;
        pulse();
        repeat (5) @(negedge clk);
        resetn = 1'b0;
        @(negedge clk);
        chk(busy, 1'b1);
        chk(res.code_valid, 1'b0);
        resetn = 1'b1;
        wait_idle();
        chk(res.code_valid, 1'b0);
        r = 16'($urandom);
        conv(r, 0);
        $display("power down and reset done");
        conclude();
    end
endmodule : tb_top
